// [tci_bus_master.sv]
// two-wire bus master model: makes the clock and frames every transfer
`timescale 1ns/100ps
module tci_bus_master (
    input wire logic i_ref_clk,
    input wire logic i_sda_oe_n,
    output logic o_scl,
    output logic o_sda
);
    logic scl_reg = 1'h1;
    logic sda_reg = 1'h1;

    // pulled-up wire, low only while one side pulls it
    assign o_sda = sda_reg & (i_sda_oe_n !== 1'h0);
    // clock stands high outside frames
    assign o_scl = scl_reg;

    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask

    // start or repeated start, ends with the clock low
    task automatic send_start();
        sda_reg <= 1'h1;
        tick(2);
        scl_reg <= 1'h1;
        tick(4);
        sda_reg <= 1'h0;
        tick(4);
        scl_reg <= 1'h0;
        tick(2);
    endtask

    task automatic send_stop();
        sda_reg <= 1'h0;
        tick(2);
        scl_reg <= 1'h1;
        tick(4);
        sda_reg <= 1'h1;
        tick(4);
    endtask

    // 32 ns clock: data set while low, held over the high phase
    task automatic xfer_bit(input logic b, output logic s);
        sda_reg <= b;
        tick(2);
        scl_reg <= 1'h1;
        tick(4);
        s = o_sda;
        scl_reg <= 1'h0;
        tick(2);
    endtask

    // msb first, ninth clock carries the slave's acknowledge
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            xfer_bit(d[i], s);
        end
        xfer_bit(1'h1, s);
        ack = !s;
    endtask

    // mack high: master acknowledges and asks for another byte
    task automatic read_byte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            xfer_bit(1'h1, s);
            d[i] = s;
        end
        xfer_bit(!mack, s);
    endtask
endmodule // tci_bus_master

// [tci_fifo.sv]
// small first-in first-out buffer with valid/ready on both sides
`timescale 1ns/100ps
module tci_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW:0] wr_ptr_reg;
    logic [PW:0] rd_ptr_reg;
    logic do_push;
    logic do_pop;

    assign o_in_ready = (wr_ptr_reg - rd_ptr_reg) != (PW+1)'(DEPTH);
    assign o_out_valid = wr_ptr_reg != rd_ptr_reg;
    assign o_out_data = mem_reg[rd_ptr_reg[PW-1:0]];
    assign do_push = i_in_valid && o_in_ready;
    assign do_pop = o_out_valid && i_out_ready;

    always_ff @(posedge i_ref_clk)
    begin
        if (do_push)
        begin
            mem_reg[wr_ptr_reg[PW-1:0]] <= i_in_data;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end
        else
        begin
            if (do_push)
            begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_pop)
            begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end
endmodule // tci_fifo

// [tci_pkg.sv]
// constants and types shared by the touch controller serial slave port
package tci_pkg;

    // own slave address: low bit comes from the address select input
    localparam logic [6:0] TCI_SLV_ADDR_BASE = 7'h4c;
    localparam logic [6:0] TCI_SLV_ADDR_ALT = 7'h4d;

    // register space
    localparam int TCI_MEM_AW = 4;
    localparam int TCI_DATA_W = 8;
    localparam logic [7:0] TCI_REG_FIRST = 8'h00;
    localparam logic [7:0] TCI_REG_LAST = 8'h0b;
    localparam logic [7:0] TCI_REG_EVENT = 8'h00;
    localparam logic [7:0] TCI_REG_CFG = 8'h0a;
    localparam int TCI_CFG_COMM_EN_BIT = 0;
    localparam logic [7:0] TCI_CFG_RESET = 8'h00;

    // write buffer: pointer plus data per entry
    localparam int TCI_FIFO_DEPTH = 4;
    localparam int TCI_FIFO_W = 16;

    // serial byte framing
    localparam int TCI_CNT_W = 4;
    localparam logic [3:0] TCI_BYTE_BITS = 4'h8;
    localparam logic [3:0] TCI_CNT_ONE = 4'h1;

    // synchroniser slots
    localparam int TCI_SYNC_W = 4;
    localparam int TCI_SYN_SCL = 3;
    localparam int TCI_SYN_SDA = 2;
    localparam int TCI_SYN_ATTENTION_INPUT = 1;
    localparam int TCI_SYN_ASEL = 0;

    typedef enum logic [6:0] {
        TCI_ST_IDLE = 7'b0000001,
        TCI_ST_ADDR = 7'b0000010,
        TCI_ST_ACK_A = 7'b0000100,
        TCI_ST_RX = 7'b0001000,
        TCI_ST_ACK_R = 7'b0010000,
        TCI_ST_TX = 7'b0100000,
        TCI_ST_ACK_M = 7'b1000000
    } tci_state_t;

endpackage

// [tci_reg_mem.sv]
// register space storage with one write port and a registered read port
`timescale 1ns/100ps
module tci_reg_mem #(
    parameter int AW = 4,
    parameter int DW = 8
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_wr_en,
    input wire logic [AW-1:0] i_wr_addr,
    input wire logic [DW-1:0] i_wr_data,
    input wire logic i_rd_en,
    input wire logic [AW-1:0] i_rd_addr,
    output logic [DW-1:0] o_rd_data
);
    logic [DW-1:0] mem_reg [2**AW];

    always_ff @(posedge i_ref_clk)
    begin
        if (i_wr_en)
        begin
            mem_reg[i_wr_addr] <= i_wr_data;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            o_rd_data <= '0;
        end
        else if (i_rd_en)
        begin
            o_rd_data <= mem_reg[i_rd_addr];
        end
    end
endmodule // tci_reg_mem

// [tci_slave_port.sv]
// two-wire serial slave port of the rotary touch controller
// Operation
// - attention low sets communication enable bit
// - events pull open-drain interrupt line low
// - address 0x4c, or 0x4d when select high
// - clock input only; data open-drain, never high
// - start and stop seen while clock high
// - one bit per clock, stable while high
// - ninth clock carries acknowledge, held low
// - device acks writes, master acks reads
// - eighth address bit selects read or write
// - watch for start plus own address, ack only while communication is enabled
// - first written byte is the command byte
// - stop after command only keeps pointer
// - first data byte goes to pointed register
// - pointer advances after each accepted data byte
// - reads start at pointer and auto-increment
`timescale 1ns/100ps
module tci_slave_port (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe_n,
    input wire logic i_attention_input_n,
    input wire logic i_address_select_input,
    input wire logic i_event,
    output logic o_irq_out,
    output logic o_irq_oe_n,
    output logic o_comm_enable_bit
);
    import tci_pkg::*;

    logic [TCI_SYNC_W-1:0] raw_in;
    logic [TCI_SYNC_W-1:0] sync1_reg;
    logic [TCI_SYNC_W-1:0] sync2_reg;
    logic scl_s;
    logic sda_s;
    logic scl_d_reg;
    logic sda_d_reg;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    tci_state_t state_reg;
    logic [7:0] shift_reg;
    logic [TCI_CNT_W-1:0] cnt_reg;
    logic [7:0] ptr_reg;
    logic [7:0] ptr_next;
    logic first_reg;
    logic rw_reg;
    logic sda_drv_reg;
    logic [6:0] own_addr;
    logic addr_hit;
    logic byte_end;

    logic rd_req_reg;
    logic rd_oob_reg;
    logic rd_cfg_reg;
    logic [TCI_DATA_W-1:0] rd_data;
    logic [TCI_DATA_W-1:0] tx_byte;

    logic comm_en_reg;
    logic irq_pend_reg;

    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [TCI_FIFO_W-1:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [TCI_FIFO_W-1:0] fifo_out_data;
    logic [7:0] drain_ptr;
    logic [7:0] drain_data;
    logic drain_fire;
    logic mem_wr_en;

    // clock, data, attention and address select inputs pass two flip-flops
    assign raw_in[TCI_SYN_SCL] = i_scl;
    assign raw_in[TCI_SYN_SDA] = i_sda;
    assign raw_in[TCI_SYN_ATTENTION_INPUT] = i_attention_input_n;
    assign raw_in[TCI_SYN_ASEL] = i_address_select_input;

    generate
        for (genvar g = 0; g < TCI_SYNC_W; g++)
        begin : g_sync
            always_ff @(posedge i_ref_clk)
            begin
                if (i_sys_rst)
                begin
                    sync1_reg[g] <= 1'b1;
                    sync2_reg[g] <= 1'b1;
                end
                else
                begin
                    sync1_reg[g] <= raw_in[g];
                    sync2_reg[g] <= sync1_reg[g];
                end
            end
        end
    endgenerate

    assign scl_s = sync2_reg[TCI_SYN_SCL];
    assign sda_s = sync2_reg[TCI_SYN_SDA];

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end
        else
        begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    // clock is only ever sampled, never driven
    assign scl_rise = scl_s && !scl_d_reg;
    assign scl_fall = !scl_s && scl_d_reg;
    assign start_cond = scl_s && scl_d_reg && sda_d_reg && !sda_s;
    assign stop_cond = scl_s && scl_d_reg && !sda_d_reg && sda_s;

    // address select picks the low address bit
    assign own_addr = sync2_reg[TCI_SYN_ASEL] ? TCI_SLV_ADDR_ALT
                                              : TCI_SLV_ADDR_BASE;
    assign addr_hit = (shift_reg[7:1] == own_addr) && comm_en_reg;
    assign byte_end = scl_fall && (cnt_reg == TCI_BYTE_BITS);

    // pointer wraps past the last register
    assign ptr_next = (ptr_reg == TCI_REG_LAST) ? TCI_REG_FIRST
                                                : ptr_reg + 8'h01;

    // byte to send, with the live enable bit merged into config
    always_comb
    begin
        tx_byte = rd_oob_reg ? 8'h00 : rd_data;
        if (rd_cfg_reg)
        begin
            tx_byte[TCI_CFG_COMM_EN_BIT] = comm_en_reg;
        end
    end

    // data bytes queue for the register space; refuse when full
    assign fifo_in_valid = byte_end && (state_reg == TCI_ST_RX)
                           && !first_reg;
    assign fifo_in_data = {ptr_reg, shift_reg};

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            state_reg <= TCI_ST_IDLE;
            shift_reg <= 8'h00;
            cnt_reg <= '0;
            ptr_reg <= TCI_REG_FIRST;
            first_reg <= 1'b0;
            rw_reg <= 1'b0;
            sda_drv_reg <= 1'b0;
        end
        else if (start_cond)
        begin
            state_reg <= TCI_ST_ADDR;
            cnt_reg <= '0;
            first_reg <= 1'b1;
            sda_drv_reg <= 1'b0;
        end
        else if (stop_cond)
        begin
            // pointer is kept; back to idle with the data line released
            state_reg <= TCI_ST_IDLE;
            sda_drv_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                TCI_ST_IDLE:
                begin
                    sda_drv_reg <= 1'b0;
                end
                TCI_ST_ADDR:
                begin
                    if (scl_rise)
                    begin
                        shift_reg <= {shift_reg[6:0], sda_s};
                        cnt_reg <= cnt_reg + TCI_CNT_ONE;
                    end
                    else if (byte_end)
                    begin
                        if (addr_hit)
                        begin
                            state_reg <= TCI_ST_ACK_A;
                            sda_drv_reg <= 1'b1;
                            rw_reg <= shift_reg[0];
                        end
                        else
                        begin
                            state_reg <= TCI_ST_IDLE;
                        end
                    end
                end
                TCI_ST_ACK_A, TCI_ST_ACK_M:
                begin
                    if (scl_rise && state_reg == TCI_ST_ACK_M)
                    begin
                        if (sda_s)
                        begin
                            // master refused: stay off the bus
                            state_reg <= TCI_ST_IDLE;
                        end
                        else
                        begin
                            ptr_reg <= ptr_next;
                        end
                    end
                    else if (scl_fall)
                    begin
                        if (rw_reg)
                        begin
                            state_reg <= TCI_ST_TX;
                            sda_drv_reg <= !tx_byte[7];
                            shift_reg <= {tx_byte[6:0], 1'b0};
                            cnt_reg <= TCI_CNT_ONE;
                        end
                        else
                        begin
                            state_reg <= TCI_ST_RX;
                            sda_drv_reg <= 1'b0;
                            cnt_reg <= '0;
                        end
                    end
                end
                TCI_ST_RX:
                begin
                    if (scl_rise)
                    begin
                        shift_reg <= {shift_reg[6:0], sda_s};
                        cnt_reg <= cnt_reg + TCI_CNT_ONE;
                    end
                    else if (byte_end)
                    begin
                        state_reg <= TCI_ST_ACK_R;
                        if (first_reg)
                        begin
                            ptr_reg <= shift_reg;
                            first_reg <= 1'b0;
                            sda_drv_reg <= 1'b1;
                        end
                        else if (fifo_in_ready)
                        begin
                            ptr_reg <= ptr_next;
                            sda_drv_reg <= 1'b1;
                        end
                        else
                        begin
                            sda_drv_reg <= 1'b0;
                        end
                    end
                end
                TCI_ST_ACK_R:
                begin
                    if (scl_fall)
                    begin
                        state_reg <= TCI_ST_RX;
                        sda_drv_reg <= 1'b0;
                        cnt_reg <= '0;
                    end
                end
                TCI_ST_TX:
                begin
                    if (scl_fall)
                    begin
                        if (cnt_reg == TCI_BYTE_BITS)
                        begin
                            // release for the master's acknowledge
                            state_reg <= TCI_ST_ACK_M;
                            sda_drv_reg <= 1'b0;
                        end
                        else
                        begin
                            sda_drv_reg <= !shift_reg[7];
                            shift_reg <= {shift_reg[6:0], 1'b0};
                            cnt_reg <= cnt_reg + TCI_CNT_ONE;
                        end
                    end
                end
                default:
                begin
                    state_reg <= TCI_ST_IDLE;
                    sda_drv_reg <= 1'b0;
                end
            endcase
        end
    end

    // fetch one cycle after the ack clock rises, on the settled pointer
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            rd_req_reg <= 1'b0;
            rd_oob_reg <= 1'b0;
            rd_cfg_reg <= 1'b0;
        end
        else
        begin
            rd_req_reg <= scl_rise && !start_cond && !stop_cond
                          && ((state_reg == TCI_ST_ACK_A && rw_reg)
                          || (state_reg == TCI_ST_ACK_M && !sda_s));
            if (rd_req_reg)
            begin
                rd_oob_reg <= ptr_reg > TCI_REG_LAST;
                rd_cfg_reg <= ptr_reg == TCI_REG_CFG;
            end
        end
    end

    // reads own the storage port; the write buffer waits
    assign fifo_out_ready = !rd_req_reg;
    assign drain_fire = fifo_out_valid && fifo_out_ready;
    assign drain_ptr = fifo_out_data[15:8];
    assign drain_data = fifo_out_data[7:0];
    assign mem_wr_en = drain_fire && (drain_ptr <= TCI_REG_LAST);

    tci_fifo #(
        .WIDTH(TCI_FIFO_W),
        .DEPTH(TCI_FIFO_DEPTH)
    ) u_wr_fifo (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_in_valid(fifo_in_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data(fifo_in_data),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_out_ready),
        .o_out_data(fifo_out_data)
    );

    tci_reg_mem #(
        .AW(TCI_MEM_AW),
        .DW(TCI_DATA_W)
    ) u_reg_mem (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_wr_en(mem_wr_en),
        .i_wr_addr(drain_ptr[TCI_MEM_AW-1:0]),
        .i_wr_data(drain_data),
        .i_rd_en(rd_req_reg),
        .i_rd_addr(ptr_reg[TCI_MEM_AW-1:0]),
        .o_rd_data(rd_data)
    );

    // attention low forces the enable on; a config write may clear it
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            comm_en_reg <= TCI_CFG_RESET[TCI_CFG_COMM_EN_BIT];
        end
        else if (!sync2_reg[TCI_SYN_ATTENTION_INPUT])
        begin
            comm_en_reg <= 1'b1;
        end
        else if (mem_wr_en && drain_ptr == TCI_REG_CFG)
        begin
            comm_en_reg <= drain_data[TCI_CFG_COMM_EN_BIT];
        end
    end

    // event pending until the event register is fetched; set wins
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            irq_pend_reg <= 1'b0;
        end
        else if (i_event)
        begin
            irq_pend_reg <= 1'b1;
        end
        else if (rd_req_reg && ptr_reg == TCI_REG_EVENT)
        begin
            irq_pend_reg <= 1'b0;
        end
    end

    // open-drain pins: only ever pull low
    assign o_sda_out = 1'b0;
    assign o_sda_oe_n = !sda_drv_reg;
    assign o_irq_out = 1'b0;
    assign o_irq_oe_n = !irq_pend_reg;
    assign o_comm_enable_bit = comm_en_reg;

endmodule // tci_slave_port

// [tci_slave_port_props.sv]
// concurrent checks on the pins of the touch controller serial slave port
`timescale 1ns/100ps
module tci_slave_port_props (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda_out,
    input wire logic o_sda_oe_n,
    input wire logic i_attention_input_n,
    input wire logic i_address_select_input,
    input wire logic i_event,
    input wire logic o_irq_out,
    input wire logic o_irq_oe_n,
    input wire logic o_comm_enable_bit
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_sys_rst);

    sequence seq_attention_input_low;
        !i_attention_input_n [*6];
    endsequence
    sequence seq_start;
        i_scl && $fell(i_sda);
    endsequence
    sequence seq_stop;
        i_scl && $rose(i_sda);
    endsequence

    AST_SDA_OUT_LOW: assert property (!o_sda_out)
        else $error("data pin output value is not low");
    AST_IRQ_OUT_LOW: assert property (!o_irq_out)
        else $error("interrupt pin output value is not low");
    AST_EVENT_IRQ: assert property (i_event |=> !o_irq_oe_n)
        else $error("event did not pull the interrupt line");
    AST_IRQ_SET_WINS: assert property ($rose(o_irq_oe_n) |-> !$past(i_event))
        else $error("interrupt released right after an event");
    AST_ATTENTION_INPUT_EN: assert property (seq_attention_input_low |-> o_comm_enable_bit)
        else $error("attention low but communication not enabled");
    AST_SDA_SCL_LOW: assert property ($changed(o_sda_oe_n) |-> !$past(i_scl))
        else $error("data drive changed while clock high");
    AST_DRIVE_STANDS: assert property ($fell(o_sda_oe_n) |-> !o_sda_oe_n [*6])
        else $error("data pulled low for too short a time");
    AST_ACK_NEEDS_EN: assert property ($fell(o_sda_oe_n) |-> o_comm_enable_bit)
        else $error("data line pulled while communication disabled");
    AST_START_RELEASED: assert property (seq_start |-> o_sda_oe_n)
        else $error("data line pulled during a start");
    AST_STOP_IDLE: assert property (seq_stop |=> o_sda_oe_n [*8])
        else $error("data line pulled right after a stop");
endmodule // tci_slave_port_props

bind tci_slave_port tci_slave_port_props u_props (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_scl(i_scl),
    .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n),
    .i_attention_input_n(i_attention_input_n),
    .i_address_select_input(i_address_select_input),
    .i_event(i_event), .o_irq_out(o_irq_out), .o_irq_oe_n(o_irq_oe_n),
    .o_comm_enable_bit(o_comm_enable_bit)
);

// [test_touch_ctrl_i2c_slave_port.sv]
// self-checking bench for the touch controller serial slave port
`timescale 1ns/100ps
module test_touch_ctrl_i2c_slave_port;
    import tci_pkg::*;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic attention_input_n = 1'h1;
    logic asel = 1'h0;
    logic evt = 1'h0;
    logic scl, sda, sda_out, sda_oe_n, irq_out, irq_oe_n, comm_en;
    int err_total = 0;
    int cmp_count = 0;
    logic [7:0] rd_buf [4];

    always #2 clk = ~clk;

    tci_slave_port dut (
        .i_ref_clk(clk), .i_sys_rst(rst), .i_scl(scl), .i_sda(sda),
        .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n),
        .i_attention_input_n(attention_input_n), .i_address_select_input(asel),
        .i_event(evt), .o_irq_out(irq_out), .o_irq_oe_n(irq_oe_n),
        .o_comm_enable_bit(comm_en)
    );
    tci_bus_master u_mst (
        .i_ref_clk(clk), .i_sda_oe_n(sda_oe_n), .o_scl(scl), .o_sda(sda)
    );

    task automatic print_verdict();
        $display("compares %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
        begin
            $display("RESULT: PASS");
        end
        else
        begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    function automatic logic [7:0] addr_byte(input logic rd);
        return {(asel ? TCI_SLV_ADDR_ALT : TCI_SLV_ADDR_BASE), rd};
    endfunction

    // start, own address for writing, command byte
    task automatic set_ptr(input logic [7:0] ptr);
        logic a;
        u_mst.send_start();
        u_mst.write_byte(addr_byte(1'h0), a);
        chk_bit(a, 1'h1);
        u_mst.write_byte(ptr, a);
        chk_bit(a, 1'h1);
    endtask

    task automatic wr_data(input logic [7:0] d);
        logic a;
        u_mst.write_byte(d, a);
        chk_bit(a, 1'h1);
    endtask

    // (repeated) start, read n bytes, the last one refused, stop
    task automatic rd_bytes(input int n);
        logic a;
        u_mst.send_start();
        u_mst.write_byte(addr_byte(1'h1), a);
        chk_bit(a, 1'h1);
        for (int i = 0; i < n; i++)
        begin
            u_mst.read_byte(i < n - 1, rd_buf[i]);
        end
        u_mst.send_stop();
    endtask

    task automatic t_reset();
        logic a;
        chk_bit(sda_oe_n, 1'h1);
        chk_bit(irq_oe_n, 1'h1);
        chk_bit(comm_en, 1'h0);
        chk_bit(sda_out, 1'h0);
        chk_bit(irq_out, 1'h0);
        u_mst.send_start();
        u_mst.write_byte(addr_byte(1'h0), a);
        chk_bit(a, 1'h0);
        u_mst.send_stop();
    endtask

    task automatic t_attention();
        attention_input_n <= 1'h0;
        wait_clk(3);
        #1;
        chk_bit(comm_en, 1'h1);
        wait_clk(1);
    endtask

    // own address answered, the other one and its next byte ignored
    task automatic t_address();
        logic a;
        for (int s = 0; s < 2; s++)
        begin
            asel <= s[0];
            wait_clk(4);
            for (int k = 0; k < 2; k++)
            begin
                u_mst.send_start();
                u_mst.write_byte({7'h4c | k[6:0], 1'h0}, a);
                chk_bit(a, k == s);
                u_mst.write_byte(8'h00, a);
                chk_bit(a, k == s);
                u_mst.send_stop();
            end
        end
        asel <= 1'h0;
        wait_clk(4);
    endtask

    task automatic t_burst();
        set_ptr(8'h02);
        wr_data(8'ha1);
        wr_data(8'ha2);
        wr_data(8'ha3);
        u_mst.send_stop();
        set_ptr(8'h03);
        u_mst.send_stop();
        rd_bytes(1);
        chk_byte(rd_buf[0], 8'ha2);
        set_ptr(8'h02);
        rd_bytes(3);
        chk_byte(rd_buf[0], 8'ha1);
        chk_byte(rd_buf[1], 8'ha2);
        chk_byte(rd_buf[2], 8'ha3);
        // refused last byte leaves the pointer where it was
        rd_bytes(1);
        chk_byte(rd_buf[0], 8'ha3);
    endtask

    task automatic t_wrap();
        logic a;
        set_ptr(TCI_REG_LAST);
        wr_data(8'h5c);
        wr_data(8'h3e);
        u_mst.send_stop();
        set_ptr(8'h0c);
        u_mst.write_byte(8'h77, a);
        u_mst.send_stop();
        set_ptr(TCI_REG_LAST);
        rd_bytes(2);
        chk_byte(rd_buf[0], 8'h5c);
        chk_byte(rd_buf[1], 8'h3e);
        set_ptr(8'h0c);
        rd_bytes(1);
        chk_byte(rd_buf[0], 8'h00);
    endtask

    task automatic t_irq();
        evt <= 1'h1;
        wait_clk(1);
        evt <= 1'h0;
        wait_clk(1);
        #1;
        chk_bit(irq_oe_n, 1'h0);
        wait_clk(40);
        chk_bit(irq_oe_n, 1'h0);
        set_ptr(TCI_REG_EVENT);
        rd_bytes(1);
        chk_bit(irq_oe_n, 1'h1);
    endtask

    // attention low wins over a config write; with it high a write clears
    task automatic t_config();
        logic a;
        set_ptr(TCI_REG_CFG);
        wr_data(8'h00);
        u_mst.send_stop();
        chk_bit(comm_en, 1'h1);
        set_ptr(TCI_REG_CFG);
        rd_bytes(1);
        chk_byte(rd_buf[0], 8'h01);
        attention_input_n <= 1'h1;
        wait_clk(4);
        set_ptr(TCI_REG_CFG);
        wr_data(8'h00);
        u_mst.send_stop();
        chk_bit(comm_en, 1'h0);
        u_mst.send_start();
        u_mst.write_byte(addr_byte(1'h0), a);
        chk_bit(a, 1'h0);
        u_mst.send_stop();
        attention_input_n <= 1'h0;
        wait_clk(4);
        #1;
        chk_bit(comm_en, 1'h1);
    endtask

    initial
    begin
        wait_clk(10);
        rst <= 1'h0;
        wait_clk(4);
        t_reset();
        t_attention();
        t_address();
        t_burst();
        t_wrap();
        t_irq();
        t_config();
        print_verdict();
    end

    initial
    begin
        wait_clk(40000);
        err_total++;
        print_verdict();
    end
endmodule // test_touch_ctrl_i2c_slave_port
